// >>> fwpl_cfg.svh
// Purpose: Constants for the flash write-protection logic.
// Assumes: 4 MB array, 22-bit byte address, 64 KB blocks.
// Notes: Opcodes are plain defaults; the command set is not fixed here.
`ifndef FWPL_CFG_SVH
`define FWPL_CFG_SVH

`define FWPL_ADDR_W 22
`define FWPL_CNT_W 12
`define FWPL_ARRAY_LAST 22'h3FFFFF
`define FWPL_ZERO_ADDR 22'h000000
`define FWPL_SIZE_ONE 23'h000001
`define FWPL_BLK_LSB 16
`define FWPL_BLK_MSB 21
`define FWPL_NUM_BLOCKS 64

// Region size exponents: 64 KB steps and 4 KB steps, 32 KB cap
`define FWPL_BLK_SHIFT_BASE 5'h0F
`define FWPL_SEC_SHIFT_BASE 5'h0B
`define FWPL_SEC_SHIFT_MAX 5'h0F
`define FWPL_BP_LOW_NONE 3'h0
`define FWPL_BP_LOW_ALL 3'h7

// Erase and program granules as address masks
`define FWPL_MASK_PAGE 22'h0000FF
`define FWPL_MASK_SECTOR 22'h000FFF
`define FWPL_MASK_B32 22'h007FFF
`define FWPL_MASK_B64 22'h00FFFF

// Frame lengths in bits
`define FWPL_LEN_OP 12'h008
`define FWPL_LEN_SR1 12'h010
`define FWPL_LEN_SR2 12'h018
`define FWPL_LEN_ADDR 12'h020
`define FWPL_LEN_PP_MIN 12'h028
`define FWPL_CNT_MAX 12'hFFF

// Byte slots within a frame
`define FWPL_SLOT_OP 9'h000
`define FWPL_SLOT_A2 9'h001
`define FWPL_SLOT_A1 9'h002
`define FWPL_SLOT_A0 9'h003
`define FWPL_BIT_LAST 3'h7

// Opcodes
`define FWPL_OPC_WRITE_ENABLE_COMMAND 8'h06
`define FWPL_OPC_WRDI 8'h04
`define FWPL_OPC_WRSR 8'h01
`define FWPL_OPC_PP 8'h02
`define FWPL_OPC_SE 8'h20
`define FWPL_OPC_BE32 8'h52
`define FWPL_OPC_BE64 8'hD8
`define FWPL_OPC_CE 8'h60
`define FWPL_OPC_CE_ALT 8'hC7
`define FWPL_OPC_DP 8'hB9
`define FWPL_OPC_RDP 8'hAB
`define FWPL_OPC_BLK_LOCK 8'h36
`define FWPL_OPC_BLK_UNLOCK 8'h39
`define FWPL_OPC_ALL_LOCK 8'h7E
`define FWPL_OPC_ALL_UNLOCK 8'h98

// Status layout, byte 1 then byte 2
`define FWPL_SR_BP_LSB 2
`define FWPL_SR_BP_MSB 6
`define FWPL_SR_STATUS_PROTECT_BIT_0 7
`define FWPL_SR2_STATUS_PROTECT_BIT_1 0
`define FWPL_SR2_WPS 2
`define FWPL_SR2_CMP 6
`define FWPL_SR_RESET 9'h000

`endif

// >>> fwpl_core.sv
// Purpose: Command front end and write-protection gate of a serial NOR flash.
// Assumes: SPI mode 0/3 pins sampled by clk_sys; link clock well below clk_sys/4.
// Notes: Emits accepted array operations; the array itself sits outside.
// Contract
// - Top protect bit clear: protect top or bottom 1/64..1/2 in 64 KB blocks.
// - Low protect code 000 protects nothing, 111 protects the whole array.
// - Top protect bit set: 4/8/16/32 KB region; 10x and 110 give 32 KB.
// - Complement bit inverts the region; 000 protects all, 111 nothing.
// - Discard program or erase touching any protected address.
// - Individual lock bits count only while per-block lock select is one.
// - All individual lock bits are set after power-up.
// - Data-changing commands need the write-enable latch set first; global lock and unlock (7E, 98) are obeyed without it.
// - Write-protect pin low freezes the block-protect and status-protect bits.
// - In deep power-down only the release command is obeyed.
// - Command length must be whole bytes, ending on a byte boundary.
// - Reset forces the command machine to standby.
// - Array changes only after a complete, exact command sequence.
// - After reset the status register reads zero.
// - Misaligned chip-select release rejects the command, state unchanged.
`timescale 1ns/1ps
`include "fwpl_cfg.svh"
module fwpl_core
  import fwpl_pkg::*;
#(
  parameter int NUM_BLOCKS = `FWPL_NUM_BLOCKS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  input wire logic wp_n,
  output fwpl_array_cmd_type array_cmd,
  output logic array_cmd_valid,
  output logic cmd_reject,
  output logic write_enable_latch,
  output logic deep_power_down,
  output fwpl_status_type status,
  output logic [NUM_BLOCKS-1:0] block_lock
);
  typedef enum logic [1:0] {
    FWPL_ST_STANDBY = 2'b00,
    FWPL_ST_SHIFT = 2'b01,
    FWPL_ST_IGNORE = 2'b10
  } fwpl_state_type;

  logic [2:0] pins_sync;
  logic cs_n_s, sclk_s, si_s;
  logic wp_n_s;
  logic cs_n_d_reg, sclk_d_reg;
  logic cs_fall, cs_rise, sclk_rise;
  fwpl_state_type state_reg;
  logic [`FWPL_CNT_W-1:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] opcode_reg;
  logic [21:0] addr_reg;
  logic [7:0] sr1_byte_reg, sr2_byte_reg;
  logic [8:0] slot;
  logic byte_done;
  fwpl_region_type region;

  fwpl_sync #(.WIDTH(3), .RESET_VAL(3'h5)) u_spi_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({spi_cs_n, spi_sclk, spi_si}),
    .sync_out(pins_sync)
  );

  fwpl_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_wp_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(wp_n),
    .sync_out(wp_n_s)
  );

  assign cs_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign si_s = pins_sync[0];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cs_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else if (clk_en) begin
      cs_n_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign cs_fall = cs_n_d_reg && !cs_n_s;
  assign cs_rise = !cs_n_d_reg && cs_n_s;
  assign sclk_rise = !sclk_d_reg && sclk_s && !cs_n_s;
  assign shift_next = {shift_reg[6:0], si_s};
  assign slot = bit_cnt_reg[11:3];
  assign byte_done = sclk_rise && (bit_cnt_reg[2:0] == `FWPL_BIT_LAST);

  // Frame state; reset and every frame end return to standby
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= FWPL_ST_STANDBY;
    end else if (clk_en) begin
      unique case (state_reg)
        FWPL_ST_STANDBY: begin
          if (cs_fall) begin
            state_reg <= FWPL_ST_SHIFT;
          end
        end
        FWPL_ST_SHIFT: begin
          if (cs_rise) begin
            state_reg <= FWPL_ST_STANDBY;
          end else if (byte_done && slot == `FWPL_SLOT_OP && deep_power_down
                       && shift_next != `FWPL_OPC_RDP) begin
            state_reg <= FWPL_ST_IGNORE;
          end
        end
        FWPL_ST_IGNORE: begin
          if (cs_rise) begin
            state_reg <= FWPL_ST_STANDBY;
          end
        end
        default: begin
          state_reg <= FWPL_ST_STANDBY;
        end
      endcase
    end
  end

  // Bit counter and byte capture
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= '0;
      shift_reg <= 8'h00;
      opcode_reg <= 8'h00;
      addr_reg <= `FWPL_ZERO_ADDR;
      sr1_byte_reg <= 8'h00;
      sr2_byte_reg <= 8'h00;
    end else if (clk_en) begin
      if (cs_fall) begin
        bit_cnt_reg <= '0;
      end else if (state_reg == FWPL_ST_SHIFT && sclk_rise) begin
        shift_reg <= shift_next;
        if (bit_cnt_reg != `FWPL_CNT_MAX) begin
          bit_cnt_reg <= bit_cnt_reg + 12'h001;
        end
        if (byte_done) begin
          unique case (slot)
            `FWPL_SLOT_OP: opcode_reg <= shift_next;
            `FWPL_SLOT_A2: begin
              addr_reg[21:16] <= shift_next[5:0];
              sr1_byte_reg <= shift_next;
            end
            `FWPL_SLOT_A1: begin
              addr_reg[15:8] <= shift_next;
              sr2_byte_reg <= shift_next;
            end
            `FWPL_SLOT_A0: addr_reg[7:0] <= shift_next;
            default: begin
            end
          endcase
        end
      end
    end
  end

  fwpl_region_decode u_region (
    .block_protect(status.block_protect),
    .protect_complement(status.protect_complement),
    .region(region)
  );

  // Decode of the finished frame, valid in the cs_rise cycle
  logic frame_ok;
  logic len_op, len_addr, len_sr1, len_sr2, len_pp, aligned;
  logic is_array_op;
  fwpl_op_type op_kind;
  logic [21:0] op_mask, op_lo, op_hi;
  logic region_hit, lock_hit, op_protected;

  assign aligned = (bit_cnt_reg[2:0] == 3'h0);
  assign len_op = (bit_cnt_reg == `FWPL_LEN_OP);
  assign len_sr1 = (bit_cnt_reg == `FWPL_LEN_SR1);
  assign len_sr2 = (bit_cnt_reg == `FWPL_LEN_SR2);
  assign len_addr = (bit_cnt_reg == `FWPL_LEN_ADDR);
  assign len_pp = aligned && (bit_cnt_reg >= `FWPL_LEN_PP_MIN);
  assign frame_ok = cs_rise && state_reg == FWPL_ST_SHIFT;

  always_comb begin
    is_array_op = 1'b0;
    op_kind = FWPL_OP_PAGE;
    op_mask = `FWPL_MASK_PAGE;
    unique case (opcode_reg)
      `FWPL_OPC_PP: begin
        is_array_op = len_pp;
      end
      `FWPL_OPC_SE: begin
        is_array_op = len_addr;
        op_kind = FWPL_OP_SECTOR;
        op_mask = `FWPL_MASK_SECTOR;
      end
      `FWPL_OPC_BE32: begin
        is_array_op = len_addr;
        op_kind = FWPL_OP_BLOCK32;
        op_mask = `FWPL_MASK_B32;
      end
      `FWPL_OPC_BE64: begin
        is_array_op = len_addr;
        op_kind = FWPL_OP_BLOCK64;
        op_mask = `FWPL_MASK_B64;
      end
      `FWPL_OPC_CE, `FWPL_OPC_CE_ALT: begin
        is_array_op = len_op;
        op_kind = FWPL_OP_CHIP;
        op_mask = `FWPL_ARRAY_LAST;
      end
      default: begin
      end
    endcase
  end

  // Whole granule is checked; a page never straddles a 4 KB region edge
  assign op_lo = addr_reg & ~op_mask;
  assign op_hi = addr_reg | op_mask;
  assign region_hit = !region.none && op_lo <= region.hi && op_hi >= region.lo;
  assign lock_hit = (op_kind == FWPL_OP_CHIP) ? |block_lock
                    : block_lock[op_lo[`FWPL_BLK_MSB:`FWPL_BLK_LSB]];
  assign op_protected = status.per_block_lock_select ? lock_hit : region_hit;

  logic accept_array;
  assign accept_array = frame_ok && is_array_op && write_enable_latch
                        && !op_protected;

  // Array command issue
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      array_cmd_valid <= 1'b0;
      array_cmd <= '0;
    end else if (clk_en) begin
      array_cmd_valid <= accept_array;
      if (accept_array) begin
        array_cmd.op <= op_kind;
        array_cmd.addr <= op_lo;
      end
    end
  end

  // Rejected: misaligned end, unknown length, missing latch or protected
  logic known_ok;
  always_comb begin
    unique case (opcode_reg)
      `FWPL_OPC_WRITE_ENABLE_COMMAND, `FWPL_OPC_WRDI, `FWPL_OPC_DP, `FWPL_OPC_RDP,
      `FWPL_OPC_ALL_LOCK, `FWPL_OPC_ALL_UNLOCK: known_ok = len_op;
      `FWPL_OPC_WRSR: known_ok = (len_sr1 || len_sr2) && write_enable_latch;
      `FWPL_OPC_BLK_LOCK, `FWPL_OPC_BLK_UNLOCK: known_ok = len_addr && write_enable_latch;
      default: known_ok = accept_array;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmd_reject <= 1'b0;
    end else if (clk_en) begin
      cmd_reject <= frame_ok && !known_ok;
    end
  end

  logic wrsr_ok;
  assign wrsr_ok = frame_ok && opcode_reg == `FWPL_OPC_WRSR
                   && (len_sr1 || len_sr2) && write_enable_latch;

  // Write-enable latch: dropped after any accepted data-changing command
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      write_enable_latch <= 1'b0;
    end else if (clk_en && frame_ok) begin
      if (opcode_reg == `FWPL_OPC_WRITE_ENABLE_COMMAND && len_op) begin
        write_enable_latch <= 1'b1;
      end else if (opcode_reg == `FWPL_OPC_WRDI && len_op) begin
        write_enable_latch <= 1'b0;
      end else if (accept_array || wrsr_ok) begin
        write_enable_latch <= 1'b0;
      end else if (known_ok && opcode_reg != `FWPL_OPC_DP
                   && opcode_reg != `FWPL_OPC_RDP) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // Status bits; a one-byte write leaves the second byte untouched
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status <= `FWPL_SR_RESET;
    end else if (clk_en && wrsr_ok) begin
      if (wp_n_s) begin
        status.block_protect <= sr1_byte_reg[`FWPL_SR_BP_MSB:`FWPL_SR_BP_LSB];
        status.status_protect_bit_0 <= sr1_byte_reg[`FWPL_SR_STATUS_PROTECT_BIT_0];
        if (len_sr2) begin
          status.status_protect_bit_1 <= sr2_byte_reg[`FWPL_SR2_STATUS_PROTECT_BIT_1];
        end
      end
      if (len_sr2) begin
        status.per_block_lock_select <= sr2_byte_reg[`FWPL_SR2_WPS];
        status.protect_complement <= sr2_byte_reg[`FWPL_SR2_CMP];
      end
    end
  end

  // Individual lock bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      block_lock <= '1;
    end else if (clk_en && frame_ok && known_ok) begin
      unique case (opcode_reg)
        `FWPL_OPC_BLK_LOCK: block_lock[addr_reg[`FWPL_BLK_MSB:`FWPL_BLK_LSB]] <= 1'b1;
        `FWPL_OPC_BLK_UNLOCK: block_lock[addr_reg[`FWPL_BLK_MSB:`FWPL_BLK_LSB]] <= 1'b0;
        `FWPL_OPC_ALL_LOCK: block_lock <= '1;
        `FWPL_OPC_ALL_UNLOCK: block_lock <= '0;
        default: begin
        end
      endcase
    end
  end

  // Deep power-down; ignored frames never reach frame_ok
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      deep_power_down <= 1'b0;
    end else if (clk_en && frame_ok && len_op) begin
      if (opcode_reg == `FWPL_OPC_DP) begin
        deep_power_down <= 1'b1;
      end else if (opcode_reg == `FWPL_OPC_RDP) begin
        deep_power_down <= 1'b0;
      end
    end
  end

endmodule

// >>> fwpl_core_properties.sv
// Purpose: Port-level assertions for fwpl_core.
// Assumes: Single clk_sys domain, resetn active low.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
module fwpl_core_properties
  import fwpl_pkg::*;
#(
  parameter int NUM_BLOCKS = 64
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wp_n,
  input fwpl_array_cmd_type array_cmd,
  input wire logic array_cmd_valid,
  input wire logic cmd_reject,
  input wire logic write_enable_latch,
  input wire logic deep_power_down,
  input fwpl_status_type status,
  input wire logic [NUM_BLOCKS-1:0] block_lock
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  a_reset_state: assert property (
    $rose(resetn) |-> status == 9'h000 && &block_lock && !write_enable_latch && !deep_power_down)
    else $error("State wrong after reset");
  a_pulse_single: assert property (
    array_cmd_valid |=> !array_cmd_valid && !cmd_reject) else $error("Accept pulse too long");
  a_valid_needs_wel: assert property (
    array_cmd_valid |-> $past(write_enable_latch)) else $error("Accept without latch");
  a_valid_clears_wel: assert property (
    array_cmd_valid |-> !write_enable_latch) else $error("Latch kept after accept");
  a_wp_freezes_bp: assert property (
    (!wp_n) [*4] |=> $stable(status.block_protect) && $stable(status.status_protect_bit_0)
    && $stable(status.status_protect_bit_1)) else $error("Protect bits moved with pin low");
  a_dpd_silent: assert property (
    deep_power_down && $past(deep_power_down) |-> !array_cmd_valid
    && $stable(write_enable_latch) && $stable(status)) else $error("Activity in power-down");
  a_cmd_holds: assert property (
    !array_cmd_valid |-> $stable(array_cmd)) else $error("Array command moved");
  a_chip_blocked: assert property (
    array_cmd_valid && array_cmd.op == FWPL_OP_CHIP |-> (status.per_block_lock_select ?
    block_lock == '0 : (status.block_protect[2:0] == 3'h0 && !status.protect_complement)
    || (status.block_protect[2:0] == 3'h7 && status.protect_complement)))
    else $error("Chip erase over protected area");
  a_wps_lock: assert property (
    array_cmd_valid && status.per_block_lock_select |-> !block_lock[array_cmd.addr[21:16]])
    else $error("Erase in locked block");
endmodule

// >>> fwpl_core_tb.sv
// Purpose: Self-checking bench for fwpl_core.
// Assumes: Host model drives the pins; seed fixed.
// Notes: Protection codes swept exhaustively.
`timescale 1ns/1ps
module fwpl_core_tb;
  import fwpl_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic wp_n = 1'b1;
  wire spi_cs_n;
  wire spi_sclk;
  wire spi_si;
  fwpl_array_cmd_type array_cmd;
  logic array_cmd_valid;
  logic cmd_reject;
  logic write_enable_latch;
  logic deep_power_down;
  fwpl_status_type status;
  fwpl_status_type st;
  logic [63:0] block_lock;
  logic [21:0] a;
  logic [5:0] blk;
  logic [21:0] edge_a [8] = '{22'h3FF000, 22'h3F7000, 22'h3F8000, 22'h200000,
    22'h1FF000, 22'h008000, 22'h007000, 22'h000000};
  int failures = 0;
  int checked = 0;
  int seed;
  always #12.5 clk_sys = ~clk_sys;
  fwpl_host_model u_host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si));
  fwpl_core #(.NUM_BLOCKS(64)) u_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si), .wp_n(wp_n),
    .array_cmd(array_cmd), .array_cmd_valid(array_cmd_valid), .cmd_reject(cmd_reject),
    .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down),
    .status(status), .block_lock(block_lock));
  function automatic logic prot(input logic [4:0] bp, input logic cmp, input logic [21:0] ad);
    logic [2:0] lo;
    logic [22:0] sz;
    logic p;
    lo = bp[2:0];
    if (bp[4]) sz = 23'h001000 << ((lo > 3'h4) ? 3'h3 : lo - 3'h1);
    else sz = 23'h010000 << (lo - 3'h1);
    p = bp[3] ? ({1'b0, ad} < sz) : ({1'b0, ad} >= 23'h400000 - sz);
    if (lo == 3'h0) p = 1'b0;
    if (lo == 3'h7) p = 1'b1;
    return p ^ cmp;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Response code: 0 silent, 1 accepted, 2 refused
  task automatic frame(input logic [63:0] bits, input int n, input logic [1:0] exp);
    logic [1:0] got;
    got = 2'h0;
    u_host.xfer(bits, n);
    for (int i = 0; i < 10 && got == 2'h0; i++) begin
      @(posedge clk_sys);
      #1 got = {cmd_reject, array_cmd_valid};
    end
    repeat (3) @(posedge clk_sys);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t response %b expected %b", $time, got, exp);
    end
  endtask
  task automatic write_enable_command;
    frame(64'h06, 8, 2'h0);
  endtask
  task automatic wrsr(input fwpl_status_type s);
    frame({8'h01, s.status_protect_bit_0, s.block_protect, 3'h0, s.protect_complement, 3'h0,
      s.per_block_lock_select, 1'b0, s.status_protect_bit_1}, 24, 2'h0);
  endtask
  initial begin
    #2400000 failures++;
    final_report();
  end
  initial begin
    seed = $urandom(5);
    repeat (8) @(posedge clk_sys);
    #2 resetn = 1'b1;
    @(posedge clk_sys);
    #1 chk_val(status, 64'h0);
    chk_val(block_lock, {64{1'b1}});
    chk_val({write_enable_latch, deep_power_down}, 64'h0);
    $display("test reset done");
    a = 22'($urandom);
    frame({8'h20, 2'h0, a}, 32, 2'h2);
    write_enable_command();
    chk_val(write_enable_latch, 64'h1);
    frame({8'h20, 2'h0, a[21:1]}, 31, 2'h2);
    chk_val(write_enable_latch, 64'h1);
    frame({8'h20, 2'h0, a}, 32, 2'h1);
    chk_val(array_cmd, {FWPL_OP_SECTOR, a & 22'h3FF000});
    chk_val(write_enable_latch, 64'h0);
    $display("test latch and length done");
    for (int k = 0; k < 64; k++) begin
      st = {3'h0, 6'(k)};
      a = k[0] ? 22'($urandom) : edge_a[k[3:1]];
      write_enable_command();
      wrsr(st);
      chk_val(status, st);
      write_enable_command();
      frame({8'h20, 2'h0, a}, 32, prot(st.block_protect, st.protect_complement, a) ?
        2'h2 : 2'h1);
    end
    $display("test protection sweep done");
    write_enable_command();
    wrsr(9'h000);
    @(posedge clk_sys);
    #2 wp_n = 1'b0;
    write_enable_command();
    wrsr(9'h1FF);
    chk_val(status, 64'h060);
    @(posedge clk_sys);
    #2 wp_n = 1'b1;
    write_enable_command();
    wrsr(9'h047);
    chk_val(status, 64'h047);
    $display("test pin protect done");
    blk = 6'($urandom);
    a = {blk, 16'($urandom)};
    write_enable_command();
    frame({8'h20, 2'h0, a}, 32, 2'h2);
    write_enable_command();
    frame({8'h39, 2'h0, blk, 16'h0}, 32, 2'h0);
    chk_val(block_lock, ~(64'h1 << blk));
    write_enable_command();
    frame({8'h20, 2'h0, a}, 32, 2'h1);
    chk_val(array_cmd, {FWPL_OP_SECTOR, a & 22'h3FF000});
    write_enable_command();
    frame(64'h60, 8, 2'h2);
    frame(64'h98, 8, 2'h0);
    chk_val(block_lock, 64'h0);
    write_enable_command();
    frame(64'hC7, 8, 2'h1);
    chk_val(array_cmd, {FWPL_OP_CHIP, 22'h0});
    write_enable_command();
    frame({8'h02, 2'h0, a, 8'hA5}, 40, 2'h1);
    chk_val(array_cmd, {FWPL_OP_PAGE, a & 22'h3FFF00});
    write_enable_command();
    frame({8'hD8, 2'h0, a}, 32, 2'h1);
    chk_val(array_cmd, {FWPL_OP_BLOCK64, a & 22'h3F0000});
    write_enable_command();
    frame({8'h36, 2'h0, blk, 16'h0}, 32, 2'h0);
    chk_val(block_lock, 64'h1 << blk);
    write_enable_command();
    frame({8'h52, 2'h0, a}, 32, 2'h2);
    frame(64'h7E, 8, 2'h0);
    chk_val(block_lock, {64{1'b1}});
    $display("test block locks done");
    @(posedge clk_sys);
    #2 resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    #2 resetn = 1'b1;
    @(posedge clk_sys);
    #1 chk_val(block_lock, {64{1'b1}});
    chk_val(status, 64'h0);
    chk_val(deep_power_down, 64'h0);
    // Frozen clock enable must swallow a whole frame
    @(posedge clk_sys);
    #2 clk_en = 1'b0;
    write_enable_command();
    @(posedge clk_sys);
    #2 clk_en = 1'b1;
    chk_val(write_enable_latch, 64'h0);
    $display("test reset and freeze done");
    write_enable_command();
    frame(64'hB9, 8, 2'h0);
    chk_val(deep_power_down, 64'h1);
    frame(64'h04, 8, 2'h0);
    chk_val(write_enable_latch, 64'h1);
    frame(64'hAB, 8, 2'h0);
    chk_val(deep_power_down, 64'h0);
    frame(64'h04, 8, 2'h0);
    chk_val(write_enable_latch, 64'h0);
    $display("test power-down done");
    final_report();
  end
endmodule
bind fwpl_core fwpl_core_properties #(.NUM_BLOCKS(NUM_BLOCKS)) u_props (.clk_sys(clk_sys),
  .resetn(resetn), .wp_n(wp_n), .array_cmd(array_cmd), .array_cmd_valid(array_cmd_valid),
  .cmd_reject(cmd_reject), .write_enable_latch(write_enable_latch),
  .deep_power_down(deep_power_down), .status(status), .block_lock(block_lock));

// >>> fwpl_host_model.sv
// Purpose: Behavioural SPI host driving the flash pins.
// Assumes: Mode 0, 200 ns link clock period.
// Notes: Clock stands still between frames.
`timescale 1ns/1ps
module fwpl_host_model (
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si
);
  logic powered = 1'b0;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
    #150200 powered = 1'b1;
  end
  // Idle data keeps toggling so stale bits never look valid
  always #50 if (spi_cs_n) spi_si = ~spi_si;
  task automatic xfer(input logic [63:0] bits, input int n);
    wait (powered);
    #13 spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_si = bits[i];
      #100 spi_sclk = 1'b1;
      #100 spi_sclk = 1'b0;
    end
    #100 spi_cs_n = 1'b1;
  endtask
endmodule

// >>> fwpl_pkg.sv
// Purpose: Types shared by the write-protection logic.
// Assumes: Constants come from fwpl_cfg.svh.
// Notes: None.
package fwpl_pkg;

  typedef enum logic [2:0] {
    FWPL_OP_PAGE = 3'b000,
    FWPL_OP_SECTOR = 3'b001,
    FWPL_OP_BLOCK32 = 3'b010,
    FWPL_OP_BLOCK64 = 3'b011,
    FWPL_OP_CHIP = 3'b100
  } fwpl_op_type;

  typedef struct packed {
    fwpl_op_type op;
    logic [21:0] addr;
  } fwpl_array_cmd_type;

  typedef struct packed {
    logic none;
    logic [21:0] lo;
    logic [21:0] hi;
  } fwpl_region_type;

  typedef struct packed {
    logic status_protect_bit_1;
    logic status_protect_bit_0;
    logic per_block_lock_select;
    logic protect_complement;
    logic [4:0] block_protect;
  } fwpl_status_type;

endpackage

// >>> fwpl_region_decode.sv
// Purpose: Decode block-protect and complement bits into one address range.
// Assumes: 4 MB array; every region, and its complement, is contiguous.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "fwpl_cfg.svh"
module fwpl_region_decode
  import fwpl_pkg::*;
(
  input wire logic [4:0] block_protect,
  input wire logic protect_complement,
  output fwpl_region_type region
);
  logic [2:0] low_code;
  logic [4:0] size_shift;
  logic [22:0] size;
  logic [21:0] size_m1;
  logic plain_none;
  logic plain_all;

  assign low_code = block_protect[2:0];
  assign plain_none = (low_code == `FWPL_BP_LOW_NONE);
  assign plain_all = (low_code == `FWPL_BP_LOW_ALL);

  always_comb begin
    if (block_protect[4]) begin
      // Codes 10x and 110 all land on the 32 KB cap
      size_shift = `FWPL_SEC_SHIFT_BASE + {2'h0, low_code};
      if (size_shift > `FWPL_SEC_SHIFT_MAX) begin
        size_shift = `FWPL_SEC_SHIFT_MAX;
      end
    end else begin
      size_shift = `FWPL_BLK_SHIFT_BASE + {2'h0, low_code};
    end
  end

  assign size = `FWPL_SIZE_ONE << size_shift;
  assign size_m1 = size[21:0] - 22'h000001;

  always_comb begin
    region.none = 1'b0;
    region.lo = `FWPL_ZERO_ADDR;
    region.hi = `FWPL_ARRAY_LAST;
    if (!protect_complement) begin
      if (plain_none) begin
        region.none = 1'b1;
      end else if (!plain_all) begin
        if (block_protect[3]) begin
          region.hi = size_m1;
        end else begin
          region.lo = `FWPL_ARRAY_LAST - size_m1;
        end
      end
    end else begin
      // Complement of a top region is the rest below, and vice versa
      if (plain_all) begin
        region.none = 1'b1;
      end else if (!plain_none) begin
        if (block_protect[3]) begin
          region.lo = size_m1 + 22'h000001;
        end else begin
          region.hi = `FWPL_ARRAY_LAST - size_m1 - 22'h000001;
        end
      end
    end
  end
endmodule

// >>> fwpl_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`include "fwpl_cfg.svh"
module fwpl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
